/* File: core/conv_defines.vh */
/*
 * Constants of the data-conversion unit: register map, command and
 * status fields, operation codes, limits and memory area layout.
 * Assumes inclusion by the unit and by any bench that drives it.
 */
`ifndef CONV_DEFINES_VH
`define CONV_DEFINES_VH

`define REG_CMD 3'h0
`define REG_SRC 3'h1
`define REG_RES 3'h2
`define REG_SEL 3'h3
`define REG_STAT 3'h4

`define CMD_OP_LSB 0
`define CMD_EXEC_BIT 3
`define CMD_SIND_BIT 4
`define CMD_RIND_BIT 5

`define STAT_BUSY_BIT 0
`define STAT_FAULT_BIT 1
`define STAT_ZERO_BIT 2

`define OP_DBL2DEC 3'h0
`define OP_TIME2SEC 3'h1
`define OP_SEC2TIME 3'h2
`define OP_DECODE 3'h3
`define OP_ENCODE 3'h4
`define OP_SEG7 3'h5

`define BIN_LIMIT 32'h05F5E0FF
`define TIME_LIMIT 32'd36000000
`define SEC_PER_HOUR 32'd3600
`define SEC_PER_MIN 32'd60
`define FIELD_MAX 8'h59
`define DIGIT_MAX 4'h3
`define HALF_MAX 4'h1

`define AREA_MSB 15
`define AREA_LSB 12
`define DATA_MEM_AREA 4'h8

`define FAULT_RST 1'b0
`define ZERO_RST 1'b0

`endif

/* File: core/bin_to_bcd.v */
/*
 * Binary to packed BCD by shift-and-add-three, purely combinational.
 * Assumes the caller keeps the input below 10**DIGITS.
 */
`timescale 1ns/100ps
module bin_to_bcd #(
    parameter IN_W = 32,
    parameter DIGITS = 8
) (
    input wire [IN_W-1:0] bin,          // binary value
    output reg [4*DIGITS-1:0] bcd       // packed decimal digits
);
    integer i;
    integer d;
    always @* begin
        bcd = {4*DIGITS{1'b0}};
        for (i = IN_W - 1; i >= 0; i = i - 1) begin
            for (d = 0; d < DIGITS; d = d + 1) begin
                if (bcd[4*d +: 4] >= 4'h5) begin
                    bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
                end
            end
            bcd = {bcd[4*DIGITS-2:0], bin[i]};
        end
    end
endmodule

/* File: core/seg7_encoder.v */
/*
 * One hex digit to a seven-segment pattern, segment a in bit 0.
 * Assumes nothing of its surroundings; bit 7 is added by the caller.
 */
`timescale 1ns/100ps
module seg7_encoder (
    input wire [3:0] digit,     // hex digit
    output reg [6:0] segs       // segments g..a
);
    always @* begin
        case (digit)
            4'h0: segs = 7'h3F;
            4'h1: segs = 7'h06;
            4'h2: segs = 7'h5B;
            4'h3: segs = 7'h4F;
            4'h4: segs = 7'h66;
            4'h5: segs = 7'h6D;
            4'h6: segs = 7'h7D;
            4'h7: segs = 7'h27;
            4'h8: segs = 7'h7F;
            4'h9: segs = 7'h6F;
            4'hA: segs = 7'h77;
            4'hB: segs = 7'h7C;
            4'hC: segs = 7'h39;
            4'hD: segs = 7'h5E;
            4'hE: segs = 7'h79;
            default: segs = 7'h71;
        endcase
    end
endmodule

/* File: core/plc_data_conversion_unit.v */
/*
 * Data-conversion execution unit: binary to BCD, time conversions,
 * decoder, encoder and segment generator over a word-wide data memory.
 * Assumes a memory whose read data stand the cycle after the strobe,
 * and a register master per the plain strobe port.
 */
// Our own choices: the register offsets and the strobed register port.
// Contract
// - binary source above 05F5E0FF: no execution, results kept.
// - convert 32-bit binary in two source words to eight BCD digits.
// - fault when decimal result would exceed 99999999.
// - zero indicator set when result is zero, cleared otherwise.
// - time source: seconds bits 0-7, minutes 8-15, hours next word.
// - time-to-seconds writes BCD seconds over two result words.
// - time-to-seconds faults on non-BCD or field above 59.
// - time ops fault when word pairs straddle a data area.
// - seconds-to-time writes seconds, minutes, then hours word.
// - seconds-to-time faults on non-BCD or 36,000,000 or more.
// - inactive execution condition: nothing changes.
// - decoder sets one bit per digit in consecutive result words.
// - selector low two digits give first digit and count, 0-3.
// - decoder wraps to source digit 0.
// - decoder faults on bad selector or result past area end.
// - encoder writes highest set bit number into selected digit.
// - encoder takes up to four words, wrapping result digits.
// - encoder faults when a source word is zero.
// - segment op writes 8-bit patterns into selected byte half.
// - segment op fills successive bytes and wraps source digits.
// - indirect pointer not BCD or past area: fault.
// - only result words are written, never sources.
// - segments a-g in bits 0-6, bit 7 clear, all sixteen digits.
`timescale 1ns/100ps
`include "conv_defines.vh"
module plc_data_conversion_unit #(
    parameter DATA_WORDS = 1000
) (
    input wire SYS_CLK,             // clock
    input wire RST_N,               // synchronous reset
    input wire [2:0] REG_ADDR,      // register index
    input wire [15:0] REG_WDATA,    // register write data
    input wire REG_WR,              // register write strobe
    input wire REG_RD,              // register read strobe
    output wire [15:0] REG_RDATA,   // read data, cycle after strobe
    output wire [15:0] MEM_ADDR,    // data memory word address
    output wire MEM_RD,             // data memory read strobe
    output wire MEM_WR,             // data memory write strobe
    output wire [15:0] MEM_WDATA,   // data memory write data
    input wire [15:0] MEM_RDATA,    // read data, cycle after strobe
    output wire BUSY,               // operation in progress
    output wire FAULT,              // fault indicator
    output wire ZERO,               // zero-result indicator
    output wire DONE                // one-cycle end of operation
);
    localparam S_IDLE = 3'd0;
    localparam S_REQ = 3'd1;
    localparam S_WAIT = 3'd2;
    localparam S_CAP = 3'd3;
    localparam S_CALC = 3'd4;
    localparam S_WR = 3'd5;
    localparam S_DONE = 3'd6;
    localparam P_SPTR = 2'd0;
    localparam P_RPTR = 2'd1;
    localparam P_DATA = 2'd2;

    reg [2:0] state_q;
    reg [1:0] phase_q;
    reg [2:0] idx_q;
    reg [2:0] op_q;
    reg sind_q;
    reg rind_q;
    reg [15:0] src_q;
    reg [15:0] res_q;
    reg [15:0] sel_q;
    reg fault_q;
    reg zero_q;
    reg done_q;
    reg [15:0] rdata_q;
    reg [15:0] mem_addr_q;
    reg mem_rd_q;
    reg mem_wr_q;
    reg [15:0] mem_wdata_q;
    reg [15:0] rdbuf_q [0:7];
    reg [63:0] wres_q;

    function bcd_ok;
        input [15:0] w;
        begin
            bcd_ok = (w[3:0] <= 4'h9) && (w[7:4] <= 4'h9) &&
                     (w[11:8] <= 4'h9) && (w[15:12] <= 4'h9);
        end
    endfunction

    function [15:0] bcd_val;
        input [15:0] w;
        begin
            bcd_val = {12'h0, w[15:12]} * 16'd1000 + {12'h0, w[11:8]} * 16'd100 +
                      {12'h0, w[7:4]} * 16'd10 + {12'h0, w[3:0]};
        end
    endfunction

    function same_area;
        input [15:0] a;
        input [15:0] b;
        begin
            same_area = (a[`AREA_MSB:`AREA_LSB] == b[`AREA_MSB:`AREA_LSB]) && (b >= a);
        end
    endfunction

    function [7:0] small_bcd;
        input [7:0] v;
        reg [7:0] t;
        reg [7:0] u;
        begin
            t = v / 8'd10;
            u = v % 8'd10;
            small_bcd = {t[3:0], u[3:0]};
        end
    endfunction

    function [3:0] top_bit;
        input [15:0] w;
        integer k;
        begin
            top_bit = 4'h0;
            for (k = 0; k < 16; k = k + 1) begin
                if (w[k]) begin
                    top_bit = k[3:0];
                end
            end
        end
    endfunction

    // segment patterns for every source nibble
    wire [6:0] seg_code [0:3];
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : seg_gen
            seg7_encoder u_seg (
                .digit(rdbuf_q[0][4*g +: 4]),
                .segs(seg_code[g])
            );
        end
    endgenerate

    // operand counts follow the operation and the selector
    wire [1:0] first = sel_q[1:0];
    wire [2:0] ndig = {1'b0, sel_q[5:4]} + 3'd1;
    wire half = sel_q[8];
    wire [2:0] seg_words = ({2'b0, half} + ndig + 3'd1) >> 1;
    wire sel_bad = (sel_q[3:0] > `DIGIT_MAX) || (sel_q[7:4] > `DIGIT_MAX) ||
                   ((op_q == `OP_SEG7) && (sel_q[11:8] > `HALF_MAX));
    reg [2:0] nsrc;
    reg [2:0] ndrd;
    reg [2:0] nwr;
    always @* begin
        case (op_q)
            `OP_DECODE: begin
                nsrc = 3'd1;
                ndrd = 3'd0;
                nwr = ndig;
            end
            `OP_ENCODE: begin
                nsrc = ndig;
                ndrd = 3'd1;
                nwr = 3'd1;
            end
            `OP_SEG7: begin
                nsrc = 3'd1;
                ndrd = seg_words;
                nwr = seg_words;
            end
            default: begin
                nsrc = 3'd2;
                ndrd = 3'd0;
                nwr = 3'd2;
            end
        endcase
    end

    wire [15:0] s0 = rdbuf_q[0];
    wire [15:0] s1 = rdbuf_q[1];
    wire [31:0] src32 = {s1, s0};
    wire [31:0] tot_sec = {16'h0, bcd_val(s1)} * `SEC_PER_HOUR +
                          {24'h0, 4'h0, s0[15:12]} * 32'd600 + {24'h0, 4'h0, s0[11:8]} * `SEC_PER_MIN +
                          {24'h0, 4'h0, s0[7:4]} * 32'd10 + {28'h0, s0[3:0]};
    wire [31:0] sec_bin = {16'h0, bcd_val(s1)} * 32'd10000 + {16'h0, bcd_val(s0)};
    wire [31:0] hrs = sec_bin / `SEC_PER_HOUR;
    wire [31:0] rem = sec_bin % `SEC_PER_HOUR;
    wire [31:0] mins = rem / `SEC_PER_MIN;
    wire [31:0] secs = rem % `SEC_PER_MIN;
    wire src_pair_ok = same_area(src_q, src_q + 16'd1);
    wire res_pair_ok = same_area(res_q, res_q + 16'd1);
    reg [31:0] b2d_in;
    wire [31:0] b2d_out;

    always @* begin
        case (op_q)
            `OP_TIME2SEC: b2d_in = tot_sec;
            `OP_SEC2TIME: b2d_in = hrs;
            default: b2d_in = src32;
        endcase
    end

    bin_to_bcd #(.IN_W(32), .DIGITS(8)) u_b2d (
        .bin(b2d_in),
        .bcd(b2d_out)
    );

    // result words and fault of the loaded operation
    reg [63:0] calc_res;
    reg calc_fault;
    reg [3:0] p;
    integer i;
    always @* begin
        calc_res = 64'h0;
        calc_fault = 1'b0;
        p = 4'h0;
        case (op_q)
            `OP_DBL2DEC: begin
                calc_res[31:0] = b2d_out;
                calc_fault = (src32 > `BIN_LIMIT);
            end
            `OP_TIME2SEC: begin
                calc_res[31:0] = b2d_out;
                calc_fault = !bcd_ok(s0) || !bcd_ok(s1) ||
                             (s0[7:0] > `FIELD_MAX) || (s0[15:8] > `FIELD_MAX) ||
                             !src_pair_ok || !res_pair_ok;
            end
            `OP_SEC2TIME: begin
                calc_res[7:0] = small_bcd(secs[7:0]);
                calc_res[15:8] = small_bcd(mins[7:0]);
                calc_res[31:16] = b2d_out[15:0];
                calc_fault = !bcd_ok(s0) || !bcd_ok(s1) ||
                             (sec_bin >= `TIME_LIMIT) || !src_pair_ok || !res_pair_ok;
            end
            `OP_DECODE: begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (i < ndig) begin
                        p = {2'b0, first} + i[3:0];
                        calc_res[16*i +: 16] = 16'h1 << s0[4*p[1:0] +: 4];
                    end
                end
                calc_fault = sel_bad ||
                             !same_area(res_q, res_q + {13'h0, ndig} - 16'd1);
            end
            `OP_ENCODE: begin
                calc_res[15:0] = rdbuf_q[4];
                for (i = 0; i < 4; i = i + 1) begin
                    if (i < ndig) begin
                        p = {2'b0, first} + i[3:0];
                        calc_res[4*p[1:0] +: 4] = top_bit(rdbuf_q[i]);
                        if (rdbuf_q[i] == 16'h0) begin
                            calc_fault = 1'b1;
                        end
                    end
                end
                if (sel_bad || !same_area(src_q, src_q + {13'h0, ndig} - 16'd1)) begin
                    calc_fault = 1'b1;
                end
            end
            `OP_SEG7: begin
                calc_res[47:0] = {rdbuf_q[6], rdbuf_q[5], rdbuf_q[4]};
                for (i = 0; i < 4; i = i + 1) begin
                    if (i < ndig) begin
                        p = {3'b0, half} + i[3:0];
                        calc_res[8*p +: 8] = {1'b0, seg_code[first + i[1:0]]};
                    end
                end
                calc_fault = sel_bad || !same_area(res_q, res_q + {13'h0, seg_words} - 16'd1);
            end
            default: begin
                calc_fault = 1'b1;
            end
        endcase
    end

    wire calc_zero = (calc_res[15:0] == 16'h0) && ((nwr < 3'd2) || (calc_res[31:16] == 16'h0)) &&
                     ((nwr < 3'd3) || (calc_res[47:32] == 16'h0)) &&
                     ((nwr < 3'd4) || (calc_res[63:48] == 16'h0));

    wire [2:0] nrd = nsrc + ndrd;
    wire [2:0] slot = (idx_q < nsrc) ? idx_q : (idx_q - nsrc + 3'd4);
    wire [15:0] ptr_val = bcd_val(MEM_RDATA);
    wire ptr_ok = bcd_ok(MEM_RDATA) && (ptr_val < DATA_WORDS[15:0]);
    wire [15:0] ptr_addr = {`DATA_MEM_AREA, 12'h0} + ptr_val;
    wire idle = (state_q == S_IDLE);

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_q <= S_IDLE;
            phase_q <= P_SPTR;
            idx_q <= 3'd0;
            op_q <= `OP_DBL2DEC;
            sind_q <= 1'b0;
            rind_q <= 1'b0;
            src_q <= 16'h0;
            res_q <= 16'h0;
            sel_q <= 16'h0;
            fault_q <= `FAULT_RST;
            zero_q <= `ZERO_RST;
            done_q <= 1'b0;
            rdata_q <= 16'h0;
            mem_addr_q <= 16'h0;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_wdata_q <= 16'h0;
            wres_q <= 64'h0;
        end else begin
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 16'h0;
            if (REG_RD) begin
                case (REG_ADDR)
                    `REG_CMD: rdata_q <= {10'h0, rind_q, sind_q, 1'b0, op_q};
                    `REG_SRC: rdata_q <= src_q;
                    `REG_RES: rdata_q <= res_q;
                    `REG_SEL: rdata_q <= sel_q;
                    `REG_STAT: rdata_q <= {13'h0, zero_q, fault_q, !idle};
                    default: rdata_q <= 16'h0;
                endcase
            end
            // writes while busy are dropped so operands stay stable
            if (REG_WR && idle) begin
                case (REG_ADDR)
                    `REG_SRC: src_q <= REG_WDATA;
                    `REG_RES: res_q <= REG_WDATA;
                    `REG_SEL: sel_q <= REG_WDATA;
                    `REG_CMD: begin
                        op_q <= REG_WDATA[`CMD_OP_LSB +: 3];
                        sind_q <= REG_WDATA[`CMD_SIND_BIT];
                        rind_q <= REG_WDATA[`CMD_RIND_BIT];
                        if (REG_WDATA[`CMD_EXEC_BIT]) begin
                            state_q <= S_REQ;
                            idx_q <= 3'd0;
                            phase_q <= REG_WDATA[`CMD_SIND_BIT] ? P_SPTR :
                                       (REG_WDATA[`CMD_RIND_BIT] ? P_RPTR : P_DATA);
                        end
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
            case (state_q)
                S_IDLE: begin
                end
                S_REQ: begin
                    mem_rd_q <= 1'b1;
                    if (phase_q == P_SPTR) begin
                        mem_addr_q <= src_q;
                    end else if (phase_q == P_RPTR) begin
                        mem_addr_q <= res_q;
                    end else if (idx_q < nsrc) begin
                        mem_addr_q <= src_q + {13'h0, idx_q};
                    end else begin
                        mem_addr_q <= res_q + {13'h0, idx_q - nsrc};
                    end
                    state_q <= S_WAIT;
                end
                S_WAIT: state_q <= S_CAP;
                S_CAP: begin
                    state_q <= S_REQ;
                    if (phase_q == P_DATA) begin
                        rdbuf_q[slot] <= MEM_RDATA;
                        idx_q <= idx_q + 3'd1;
                        if (idx_q == nrd - 3'd1) begin
                            state_q <= S_CALC;
                        end
                    end else if (!ptr_ok) begin
                        fault_q <= 1'b1;
                        state_q <= S_DONE;
                    end else if (phase_q == P_SPTR) begin
                        src_q <= ptr_addr;
                        phase_q <= rind_q ? P_RPTR : P_DATA;
                    end else begin
                        res_q <= ptr_addr;
                        phase_q <= P_DATA;
                    end
                end
                S_CALC: begin
                    idx_q <= 3'd0;
                    if (calc_fault) begin
                        fault_q <= 1'b1;
                        state_q <= S_DONE;
                    end else begin
                        fault_q <= 1'b0;
                        zero_q <= calc_zero;
                        wres_q <= calc_res;
                        state_q <= S_WR;
                    end
                end
                S_WR: begin
                    mem_wr_q <= 1'b1;
                    mem_addr_q <= res_q + {13'h0, idx_q};
                    mem_wdata_q <= wres_q[16*idx_q +: 16];
                    idx_q <= idx_q + 3'd1;
                    if (idx_q == nwr - 3'd1) begin
                        state_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    done_q <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    assign REG_RDATA = rdata_q;
    assign MEM_ADDR = mem_addr_q;
    assign MEM_RD = mem_rd_q;
    assign MEM_WR = mem_wr_q;
    assign MEM_WDATA = mem_wdata_q;
    assign BUSY = !idle;
    assign FAULT = fault_q;
    assign ZERO = zero_q;
    assign DONE = done_q;
endmodule

/* File: dv/plc_conv_properties.sv */
/* Port checks of the conversion unit, bound into it.
   Assumes conv_defines.vh for register indices and status bits. */
`timescale 1ns/100ps
`include "conv_defines.vh"
module plc_conv_properties #(
    parameter DATA_WORDS = 1000
) (
    input wire SYS_CLK, // clock
    input wire RST_N, // sync reset
    input wire [2:0] REG_ADDR, // register index
    input wire [15:0] REG_WDATA, // write data
    input wire REG_WR, // write strobe
    input wire REG_RD, // read strobe
    input wire [15:0] REG_RDATA, // read data
    input wire [15:0] MEM_ADDR, // memory address
    input wire MEM_RD, // memory read
    input wire MEM_WR, // memory write
    input wire [15:0] MEM_WDATA, // memory write data
    input wire [15:0] MEM_RDATA, // memory read data
    input wire BUSY, // busy
    input wire FAULT, // fault indicator
    input wire ZERO, // zero indicator
    input wire DONE // end pulse
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    wire cmd_wr = REG_WR && REG_ADDR == `REG_CMD && !BUSY;

    a_reset_quiet: assert property (
        $rose(RST_N) |-> !BUSY && !DONE && !FAULT && !ZERO && !MEM_RD && !MEM_WR)
        else $error("outputs not clear after reset");
    a_idle_cmd: assert property (
        cmd_wr && !REG_WDATA[`CMD_EXEC_BIT] |=> !BUSY && $stable(FAULT) && $stable(ZERO))
        else $error("command without execute started work");
    a_exec_start: assert property (
        cmd_wr && REG_WDATA[`CMD_EXEC_BIT] |=> BUSY)
        else $error("execute command did not start");
    a_done_end: assert property (DONE |=> !DONE && !BUSY)
        else $error("done not a single pulse closing the operation");
    a_idle_mem: assert property (!BUSY |-> !MEM_RD && !MEM_WR)
        else $error("memory access while idle");
    a_fault_nowr: assert property (
        $rose(FAULT) |-> !MEM_WR && !$past(MEM_WR) && !$past(MEM_WR, 2))
        else $error("result written in a faulting operation");
    a_read_gap: assert property (MEM_RD |=> !MEM_RD [*2])
        else $error("memory reads closer than three cycles");
    a_rdata_once: assert property (REG_RD ##1 !REG_RD |=> REG_RDATA == 16'h0000)
        else $error("read data held past one cycle");
    a_unmapped_rd: assert property (REG_RD && REG_ADDR > `REG_STAT |=> REG_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_stat_read: assert property (
        REG_RD && REG_ADDR == `REG_STAT && !BUSY |=> !REG_RDATA[`STAT_BUSY_BIT]
        && REG_RDATA[`STAT_FAULT_BIT] == $past(FAULT) && REG_RDATA[`STAT_ZERO_BIT] == $past(ZERO))
        else $error("status read disagrees with indicators");
    a_flag_hold: assert property (
        !BUSY ##1 !BUSY |-> $stable(FAULT) && $stable(ZERO))
        else $error("indicator moved while idle");

    c_fault_end: cover property (DONE && FAULT);
    c_zero_end: cover property (DONE && ZERO);
    c_clean_end: cover property (DONE && !FAULT && !ZERO);
endmodule

bind plc_data_conversion_unit plc_conv_properties #(.DATA_WORDS(DATA_WORDS))
    i_plc_conv_properties (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_ADDR(MEM_ADDR),
    .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .BUSY(BUSY), .FAULT(FAULT), .ZERO(ZERO), .DONE(DONE));

/* File: dv/plc_data_conversion_unit_tb_top.sv */
/* Bench of the conversion unit: a table of operations, then area
   crossing, idle command, indirect operand and reset cases.
   Assumes conv_defines.vh on the include path; the bench is the memory. */
`timescale 1ns/100ps
`include "conv_defines.vh"
module plc_data_conversion_unit_tb_top;
    typedef struct packed {
        logic [7:0] fo;
        logic [15:0] sel;
        logic [15:0] s0;
        logic [15:0] s1;
        logic [15:0] e0;
        logic [15:0] e1;
    } row_t;
    // fo: bit 7 fault expected, low bits op code; results preset to AAAA
    row_t rows [19] = '{
        '{8'h00, 16'h0000, 16'hE0FF, 16'h05F5, 16'h9999, 16'h9999},
        '{8'h80, 16'h0000, 16'hE100, 16'h05F5, 16'hAAAA, 16'hAAAA},
        '{8'h00, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000},
        '{8'h01, 16'h0000, 16'h5959, 16'h9999, 16'h9999, 16'h3599},
        '{8'h81, 16'h0000, 16'h0060, 16'h0000, 16'hAAAA, 16'hAAAA},
        '{8'h81, 16'h0000, 16'h0000, 16'h000A, 16'hAAAA, 16'hAAAA},
        '{8'h02, 16'h0000, 16'h9999, 16'h3599, 16'h5959, 16'h9999},
        '{8'h82, 16'h0000, 16'h0000, 16'h3600, 16'hAAAA, 16'hAAAA},
        '{8'h02, 16'h0000, 16'h3661, 16'h0000, 16'h0101, 16'h0001},
        '{8'h03, 16'h0013, 16'h4321, 16'h0000, 16'h0010, 16'h0002},
        '{8'h83, 16'h0004, 16'h4321, 16'h0000, 16'hAAAA, 16'hAAAA},
        '{8'h04, 16'h0013, 16'h8000, 16'h0001, 16'hFAA0, 16'hAAAA},
        '{8'h84, 16'h0000, 16'h0000, 16'h0001, 16'hAAAA, 16'hAAAA},
        '{8'h05, 16'h0030, 16'h3210, 16'h0000, 16'h063F, 16'h4F5B},
        '{8'h05, 16'h0030, 16'h7654, 16'h0000, 16'h6D66, 16'h277D},
        '{8'h05, 16'h0030, 16'hBA98, 16'h0000, 16'h6F7F, 16'h7C77},
        '{8'h05, 16'h0030, 16'hFEDC, 16'h0000, 16'h5E39, 16'h7179},
        '{8'h05, 16'h0113, 16'h0018, 16'h0000, 16'h3FAA, 16'hAA7F},
        '{8'h85, 16'h0200, 16'h0018, 16'h0000, 16'hAAAA, 16'hAAAA}
    };
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [2:0] REG_ADDR = 3'h0;
    logic [15:0] REG_WDATA = 16'h0000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [15:0] MEM_RDATA = 16'h0000;
    wire [15:0] REG_RDATA;
    wire [15:0] MEM_ADDR;
    wire [15:0] MEM_WDATA;
    wire MEM_RD;
    wire MEM_WR;
    wire BUSY;
    wire FAULT;
    wire ZERO;
    wire DONE;
    logic [15:0] mem [0:65535];
    int err_total = 0;
    int check_count = 0;

    plc_data_conversion_unit #(.DATA_WORDS(16)) i_plc_data_conversion_unit (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_ADDR(MEM_ADDR),
        .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
        .BUSY(BUSY), .FAULT(FAULT), .ZERO(ZERO), .DONE(DONE));

    always #12.5 SYS_CLK = ~SYS_CLK;

    // unread cycles show the inverse, so a late sample cannot pass
    always @(posedge SYS_CLK) begin
        if (MEM_WR) begin
            mem[MEM_ADDR] <= MEM_WDATA;
        end
        MEM_RDATA <= MEM_RD ? mem[MEM_ADDR] : ~MEM_RDATA;
    end

    task automatic close_out;
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask

    task automatic reg_rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1;
        v = REG_RDATA;
        @(posedge SYS_CLK);
        #1;
        chk(REG_RDATA, 16'h0000);
    endtask

    // source register always set to 1100; bounded wait on the done pulse
    task automatic run(input logic [2:0] op, input logic [1:0] ind, input logic [15:0] res,
                       input logic [15:0] sel);
        int n;
        reg_wr(`REG_SRC, 16'h1100);
        reg_wr(`REG_RES, res);
        reg_wr(`REG_SEL, sel);
        reg_wr(`REG_CMD, {10'h000, ind, 1'b1, op});
        n = 0;
        while (DONE !== 1'b1 && n < 300) begin
            @(posedge SYS_CLK);
            #1;
            n++;
        end
        if (n == 300) begin
            err_total++;
        end
        repeat (2) @(posedge SYS_CLK);
        #1;
    endtask

    initial begin
        row_t r;
        logic [15:0] d;
        logic ez;
        ez = 1'b0;
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        #1;
        chk({10'h000, BUSY, FAULT, ZERO, DONE, MEM_RD, MEM_WR}, 16'h0000);
        for (int i = 0; i < 19; i++) begin
            r = rows[i];
            mem[16'h1100] = r.s0;
            mem[16'h1101] = r.s1;
            mem[16'h1200] = 16'hAAAA;
            mem[16'h1201] = 16'hAAAA;
            run(r.fo[2:0], 2'b00, 16'h1200, r.sel);
            ez = r.fo[7] ? ez : (r.e0 == 16'h0000 && r.e1 == 16'h0000);
            chk({15'h0000, FAULT}, {15'h0000, r.fo[7]});
            chk({15'h0000, ZERO}, {15'h0000, ez});
            chk(mem[16'h1200], r.e0);
            chk(mem[16'h1201], r.e1);
            chk(mem[16'h1100], r.s0);
            reg_rd(`REG_STAT, d);
            chk(d & 16'h0007, {13'h0000, ez, r.fo[7], 1'b0});
        end
        // result pair straddling an area boundary
        mem[16'h1100] = 16'h0001;
        mem[16'h1101] = 16'h0000;
        mem[16'h1FFF] = 16'hAAAA;
        run(3'h1, 2'b00, 16'h1FFF, 16'h0000);
        chk({15'h0000, FAULT}, 16'h0001);
        chk(mem[16'h1FFF], 16'hAAAA);
        mem[16'h1200] = 16'hAAAA;
        reg_wr(`REG_CMD, 16'h0000);
        repeat (20) @(posedge SYS_CLK);
        #1;
        chk({14'h0000, BUSY, FAULT}, 16'h0001);
        chk(mem[16'h1200], 16'hAAAA);
        reg_rd(3'h7, d);
        chk(d, 16'h0000);
        mem[16'h1100] = 16'h0005;
        mem[16'h8005] = 16'h0012;
        mem[16'h8006] = 16'h0000;
        run(3'h0, 2'b01, 16'h1200, 16'h0000);
        chk({15'h0000, FAULT}, 16'h0000);
        chk(mem[16'h1200], 16'h0018);
        for (int k = 0; k < 2; k++) begin
            mem[16'h1100] = k ? 16'h0020 : 16'h00AB;
            run(3'h0, 2'b01, 16'h1200, 16'h0000);
            chk({15'h0000, FAULT}, 16'h0001);
            chk(mem[16'h1200], 16'h0018);
        end
        mem[16'h1100] = 16'h0063;
        mem[16'h1300] = 16'h0003;
        run(3'h0, 2'b10, 16'h1300, 16'h0000);
        chk(mem[16'h8003], 16'h0099);
        @(posedge SYS_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1;
        chk({13'h0000, BUSY, FAULT, ZERO}, 16'h0000);
        @(posedge SYS_CLK);
        RST_N <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        close_out();
    end

    initial begin
        // about 25 operations of under 100 cycles each, wide margin
        #250000;
        err_total++;
        close_out();
    end
endmodule
